// ==== tb_tlb_test_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the buffer test port, driven over its Avalon slave.
module tb_tlb_test_port;
  import tlb_test_pkg::*;
  logic clk; // Core clock, 40 ns period.
  logic sys_rst; // Synchronous reset, active high.
  avmm_req_t avs_req; // Request driven by the bench as bus master.
  logic [31:0] avs_readdata; // Read data from the port.
  logic avs_waitrequest; // Stall from the port.
  logic [31:0] rsv_readdata; // Read data from the reduced-address port.
  int fail_count; // Number of mismatches seen.
  int compares; // Number of comparisons made.
  localparam logic [19:0] LIN_A = 20'hABCD1; // Page in set 1.
  localparam logic [19:0] LIN_B = 20'h12342; // First page in set 2.
  localparam logic [19:0] LIN_C = 20'h55552; // Second page in set 2.
  localparam logic [19:0] LIN_D = 20'h0F0F3; // Page in set 3.
  localparam logic [19:0] PHYS_A = 20'h3C5A7; // Physical page stored for LIN_A.
  localparam logic [31:0] MASK_DATA = 32'hFFFF_FF9C; // Ignores only spare bits.

  tlb_test_port uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .avs_req(avs_req),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  // Second port built as the reduced-address variant, fed the same requests.
  tlb_test_port #(
    .REDUCED_ADDR(1'b1)
  ) uut_rsv (
    .clk(clk),
    .sys_rst(sys_rst),
    .avs_req(avs_req),
    .avs_readdata(rsv_readdata),
    .avs_waitrequest()
  );

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Builds a control word: page, valid bit, attribute pairs and command bit.
  function automatic logic [31:0] ctl(input logic [19:0] lin, input logic v,
                                      input logic [5:0] pr, input logic cmd);
    return {lin, v, pr, 4'h0, cmd};
  endfunction

  // Builds a data word: page, page attributes, history, hit flag and way.
  function automatic logic [31:0] dat(input logic [19:0] ph, input logic uc, input logic wt,
                                      input logic [2:0] h, input logic hit, input logic [1:0] w);
    return {ph, uc, wt, h, 2'h0, hit, w, 2'h0};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compares one 32-bit result under a mask.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got,
                       input logic [31:0] mask);
    compares++;
    if ((got & mask) !== (exp & mask)) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp & mask, got & mask);
    end
  endtask

  // Waits for waitrequest low, looked at while settled before a rising edge, with a bound.
  // The request still stands at that edge, which accepts it; read data is taken at the falling edge just before it.
  task automatic wait_accept(output logic [31:0] rd);
    int n;
    rd = 32'h0000_0000;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (avs_waitrequest === 1'b0) begin
        rd = avs_readdata;
        @(posedge clk);
        return;
      end
    end
    fail_count++;
    $display("unexpected waitrequest: expected 0, seen stuck 1");
    stop_test();
  endtask

  // One Avalon write; the request holds until it is accepted.
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] ignored_rd;
    @(posedge clk);
    avs_req <= '{address: a, read: 1'b0, write: 1'b1, writedata: d};
    wait_accept(ignored_rd);
    avs_req.write <= 1'b0;
  endtask

  // One Avalon read; data is taken at the falling edge before the accepting edge.
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_req <= '{address: a, read: 1'b1, write: 1'b0, writedata: 32'h0000_0000};
    wait_accept(d);
    avs_req.read <= 1'b0;
  endtask

  // Runs a lookup and returns both registers afterwards.
  task automatic look(input logic [19:0] lin, input logic [5:0] pr,
                      output logic [31:0] c, output logic [31:0] d);
    bus_write(OFS_CTRL, ctl(lin, 1'b1, pr, 1'b1));
    bus_read(OFS_CTRL, c);
    bus_read(OFS_DATA, d);
  endtask

  // Reset values, and the unmapped place that reads zero and ignores writes.
  task automatic t_reset();
    logic [31:0] r;
    bus_write(4'h8, 32'hFFFF_FFFF);
    bus_read(OFS_CTRL, r);
    check("control after reset", CTRL_RST, r, 32'hFFFF_FFFF);
    bus_read(OFS_DATA, r);
    check("data after reset", DATA_RST, r, 32'hFFFF_FFFF);
    bus_read(4'h8, r);
    check("unmapped read", 32'h0000_0000, r, 32'hFFFF_FFFF);
    bus_write(OFS_DATA, 32'hFFFF_FFFF);
    bus_read(OFS_DATA, r);
    check("full data", 32'hFFFF_FFFF, r, 32'hFFFF_FFFF);
    check("reserved data", 32'h00FF_FFFF, rsv_readdata, 32'hFFFF_FFFF);
    $display("test reset done");
  endtask

  // Forced write into way 3, then a lookup that reloads every field.
  task automatic t_forced_hit();
    logic [31:0] c;
    logic [31:0] d;
    bus_write(OFS_DATA, dat(PHYS_A, 1'b1, 1'b0, 3'h5, 1'b1, 2'h3));
    bus_write(OFS_CTRL, ctl(LIN_A, 1'b1, 6'b100110, 1'b0));
    bus_write(OFS_DATA, 32'h0000_0000);
    look(LIN_A, 6'b111111, c, d);
    check("hit data", dat(PHYS_A, 1'b1, 1'b0, 3'h0, 1'b1, 2'h3), d, MASK_DATA);
    check("hit control", ctl(LIN_A, 1'b1, 6'b100110, 1'b1), c, 32'hFFFF_FFFF);
    $display("test forced hit done");
  endtask

  // Attribute pair encodings on lookup against stored dirty 1, user 0.
  task automatic t_pairs();
    logic [5:0] prs [6] = '{6'b001111, 6'b011111, 6'b101111, 6'b111111,
                            6'b110111, 6'b111011};
    logic hits [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [31:0] c;
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      look(LIN_A, prs[i], c, d);
      check("pair hit flag", {27'h0, hits[i], 4'h0}, d, 32'h0000_0010);
      if (hits[i]) begin
        check("pair control", ctl(LIN_A, 1'b1, 6'b100110, 1'b1), c, 32'hFFFF_FFFF);
      end else begin
        check("miss control", ctl(LIN_A, 1'b1, prs[i], 1'b1), c, 32'hFFFF_FFFF);
        check("miss data", dat(PHYS_A, 1'b1, 1'b0, 3'h0, 1'b0, 2'h3), d, MASK_DATA);
      end
    end
    $display("test pairs done");
  endtask

  // Unforced writes follow the replacement order: way 0, then way 2.
  task automatic t_plru();
    logic [31:0] c;
    logic [31:0] d;
    bus_write(OFS_DATA, dat(20'h11111, 1'b0, 1'b1, 3'h0, 1'b0, 2'h3));
    bus_write(OFS_CTRL, ctl(LIN_B, 1'b1, 6'b010101, 1'b0));
    bus_write(OFS_DATA, dat(20'h22222, 1'b0, 1'b0, 3'h0, 1'b0, 2'h1));
    bus_write(OFS_CTRL, ctl(LIN_C, 1'b1, 6'b101010, 1'b0));
    look(LIN_B, 6'b111111, c, d);
    check("first victim", dat(20'h11111, 1'b0, 1'b1, 3'h6, 1'b1, 2'h0), d, MASK_DATA);
    check("first control", ctl(LIN_B, 1'b1, 6'b010101, 1'b1), c, 32'hFFFF_FFFF);
    look(LIN_C, 6'b111111, c, d);
    check("second victim", dat(20'h22222, 1'b0, 1'b0, 3'h7, 1'b1, 2'h2), d, MASK_DATA);
    $display("test replacement done");
  endtask

  // Two ways holding one page give a multiple match, which is a miss.
  task automatic t_multi();
    logic [31:0] c;
    logic [31:0] d;
    bus_write(OFS_DATA, dat(20'h33333, 1'b0, 1'b0, 3'h0, 1'b1, 2'h0));
    bus_write(OFS_CTRL, ctl(LIN_D, 1'b1, 6'b101010, 1'b0));
    bus_write(OFS_DATA, dat(20'h44444, 1'b0, 1'b0, 3'h0, 1'b1, 2'h1));
    bus_write(OFS_CTRL, ctl(LIN_D, 1'b1, 6'b101010, 1'b0));
    look(LIN_D, 6'b111111, c, d);
    check("multi data", dat(20'h44444, 1'b0, 1'b0, 3'h0, 1'b0, 2'h1), d, MASK_DATA);
    check("multi control", ctl(LIN_D, 1'b1, 6'b111111, 1'b1), c, 32'hFFFF_FFFF);
    $display("test multiple match done");
  endtask

  // A write with the valid bit clear removes the entry.
  task automatic t_invalidate();
    logic [31:0] c;
    logic [31:0] d;
    bus_write(OFS_DATA, dat(PHYS_A, 1'b1, 1'b0, 3'h0, 1'b1, 2'h3));
    bus_write(OFS_CTRL, ctl(LIN_A, 1'b0, 6'b100110, 1'b0));
    look(LIN_A, 6'b111111, c, d);
    check("invalid hit flag", 32'h0000_0000, d, 32'h0000_0010);
    $display("test invalidate done");
  endtask

  // Main sequence: reset, then every scenario, then the verdict.
  initial begin
    fail_count = 0;
    compares = 0;
    sys_rst = 1'b1;
    avs_req = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_forced_hit();
    t_pairs();
    t_plru();
    t_multi();
    t_invalidate();
    stop_test();
  end
endmodule
`default_nettype wire

// ==== tlb_test_pkg.sv ====
`default_nettype none
// Shared constants and types for the translation buffer test port.
package tlb_test_pkg;
  // Buffer organisation.
  localparam int NUM_WAYS = 4;
  localparam int SETS_PER_WAY = 8;
  localparam int WAY_IDX_W = 2;
  localparam int SET_IDX_W = 3;
  localparam int LIN_W = 20;
  localparam int PHYS_W = 20;
  localparam int LRU_W = 3;
  // Byte offsets of the two registers on the Avalon bus.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h4;
  // Test-control register field positions.
  localparam int CTL_CMD = 0;
  localparam int CTL_RW_C = 5;
  localparam int CTL_RW_T = 6;
  localparam int CTL_US_C = 7;
  localparam int CTL_US_T = 8;
  localparam int CTL_D_C = 9;
  localparam int CTL_D_T = 10;
  localparam int CTL_VALID = 11;
  localparam int LIN_LO = 12;
  // Test-data register field positions.
  localparam int DAT_WAY_LO = 2;
  localparam int DAT_HIT = 4;
  localparam int DAT_LRU_LO = 7;
  localparam int DAT_WTHRU = 10;
  localparam int DAT_UNCACHED = 11;
  localparam int PHYS_LO = 12;
  // Lowest bit that is reserved on the reduced-address variant.
  localparam int RSV_LO = 24;
  // Reset values, and the write mask of the reduced-address variant.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [2:0] LRU_RST = 3'h0;
  localparam logic [31:0] RSV_MASK = 32'h00FF_FFFF;
  // The 24-bit tag: linear page, valid, dirty, user, writable.
  typedef struct packed {
    logic [19:0] lin;
    logic valid;
    logic dirty;
    logic user;
    logic wr;
  } tlb_tag_t;
  // One buffer entry: tag, physical page and the two page attributes.
  typedef struct packed {
    tlb_tag_t tag;
    logic [19:0] phys;
    logic uncached;
    logic wthru;
  } tlb_entry_t;
  // Avalon-MM request from the master.
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avmm_req_t;
  // Operation sequencer states.
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } op_state_t;
endpackage
`default_nettype wire

// ==== tlb_test_port.sv ====
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Four ways of eight entries each.
// - Entry: 24-bit tag, 20-bit physical page.
// - Tag built from test-control register contents.
// - Control bit 0: write 0, lookup 1.
// - Write stores physical page for linear address.
// - Lookup updates fields other than the hit flag only on single match.
// - Write valid bit sets or invalidates entry.
// - Three attribute pairs at bits 10-5.
// - Pair encodings for lookup match and write.
// - Data bits 31-12 carry physical page.
// - Data bits 11,10 hold page attributes.
// - Lookup reports replacement bits before lookup.
// - Lookup sets hit flag on hit.
// - Write uses forced way or pseudo-LRU.
// - Way field reports hit way, forces write.
// - Reduced variant reserves bits 31-24.
module tlb_test_port #(
  parameter bit REDUCED_ADDR = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire tlb_test_pkg::avmm_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import tlb_test_pkg::*;

  // Software-visible test registers.
  logic [31:0] tlb_test_command_reg;
  logic [31:0] tlb_test_result_reg;
  // Buffer storage and per-set replacement history.
  tlb_entry_t mem [NUM_WAYS][SETS_PER_WAY];
  logic [LRU_W-1:0] lru [SETS_PER_WAY];
  // Sequencer state and bus read handshake.
  op_state_t state;
  logic rd_ready;
  // Decoded bus accesses.
  logic wr_take;
  logic wr_ctrl;
  logic wr_data;
  logic [31:0] wmask;
  // Lookup and write helpers.
  logic [SET_IDX_W-1:0] set_idx;
  logic [5:0] pairs;
  logic [NUM_WAYS-1:0] way_hit;
  logic one_hit;
  logic [WAY_IDX_W-1:0] hit_way;
  logic [WAY_IDX_W-1:0] victim;
  logic [WAY_IDX_W-1:0] target_way;
  logic [LRU_W-1:0] lru_cur;
  logic do_lookup;
  logic do_write;
  logic hit_or_force_flag;
  logic [1:0] forced_way_select;
  tlb_entry_t new_entry;
  tlb_entry_t hit_entry;

  // Pseudo-LRU victim: bit 0 picks the half, bits 1 and 2 pick within it.
  function automatic logic [WAY_IDX_W-1:0] plru_victim(input logic [LRU_W-1:0] h);
    plru_victim = h[0] ? {1'b1, h[2]} : {1'b0, h[1]};
  endfunction

  // History update: point every touched tree node away from the used way.
  function automatic logic [LRU_W-1:0] plru_touch(input logic [LRU_W-1:0] h,
                                                  input logic [WAY_IDX_W-1:0] w);
    logic [LRU_W-1:0] r;
    r = h;
    r[0] = ~w[1];
    if (w[1]) begin
      r[2] = ~w[0];
    end else begin
      r[1] = ~w[0];
    end
    plru_touch = r;
  endfunction

  // Bus decode: writes are taken only while no operation runs.
  always_comb begin
    wr_take = avs_req.write & (state == ST_IDLE);
    wr_ctrl = wr_take & (avs_req.address == OFS_CTRL);
    wr_data = wr_take & (avs_req.address == OFS_DATA);
    wmask = REDUCED_ADDR ? RSV_MASK : 32'hFFFF_FFFF;
    // Writes stall during an operation; reads wait one cycle for registered data.
    avs_waitrequest = (state == ST_EXEC) | (avs_req.read & ~rd_ready);
  end

  // Field views of the two registers.
  always_comb begin
    set_idx = tlb_test_command_reg[LIN_LO +: SET_IDX_W];
    pairs = tlb_test_command_reg[CTL_RW_C +: 6];
    hit_or_force_flag = tlb_test_result_reg[DAT_HIT];
    forced_way_select = tlb_test_result_reg[DAT_WAY_LO +: WAY_IDX_W];
    lru_cur = lru[set_idx];
    victim = plru_victim(lru_cur);
    do_lookup = (state == ST_EXEC) & tlb_test_command_reg[CTL_CMD];
    do_write = (state == ST_EXEC) & ~tlb_test_command_reg[CTL_CMD];
  end

  genvar gw;
  generate
    for (gw = 0; gw < NUM_WAYS; gw++) begin : g_way
      tlb_way_match u_match (
        .stored(mem[gw][set_idx].tag),
        .lin(tlb_test_command_reg[31:LIN_LO]),
        .pairs(pairs),
        .hit(way_hit[gw])
      );
    end
  endgenerate

  always_comb begin
    one_hit = (way_hit != 4'h0) & ((way_hit & (way_hit - 4'h1)) == 4'h0);
    hit_way = 2'h0;
    for (int i = 0; i < NUM_WAYS; i++) begin
      if (way_hit[i]) begin
        hit_way = WAY_IDX_W'(i);
      end
    end
    hit_entry = mem[hit_way][set_idx];
    target_way = hit_or_force_flag ? forced_way_select : victim;
  end

  // Entry assembled from the two registers for a test write.
  always_comb begin
    new_entry.tag.lin = tlb_test_command_reg[31:LIN_LO];
    new_entry.tag.valid = tlb_test_command_reg[CTL_VALID];
    new_entry.tag.dirty = tlb_test_command_reg[CTL_D_T];
    new_entry.tag.user = tlb_test_command_reg[CTL_US_T];
    new_entry.tag.wr = tlb_test_command_reg[CTL_RW_T];
    new_entry.phys = tlb_test_result_reg[31:PHYS_LO];
    new_entry.uncached = tlb_test_result_reg[DAT_UNCACHED];
    new_entry.wthru = tlb_test_result_reg[DAT_WTHRU];
  end

  // Sequencer: a control write starts one operation cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (wr_ctrl) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Read path: data is registered, then waitrequest drops for one cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_ready <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (avs_req.read & ~rd_ready & (state == ST_IDLE)) begin
      rd_ready <= 1'b1;
      // Unmapped addresses read as zero.
      if (avs_req.address == OFS_CTRL) begin
        avs_readdata <= tlb_test_command_reg;
      end else if (avs_req.address == OFS_DATA) begin
        avs_readdata <= tlb_test_result_reg;
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end else begin
      rd_ready <= 1'b0;
    end
  end

  // Test-control register: bus writes and single-hit lookup results.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tlb_test_command_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      tlb_test_command_reg <= avs_req.writedata & wmask;
    end else if (do_lookup & one_hit) begin
      tlb_test_command_reg[CTL_VALID] <= 1'b1;
      tlb_test_command_reg[CTL_D_T] <= hit_entry.tag.dirty;
      tlb_test_command_reg[CTL_D_C] <= ~hit_entry.tag.dirty;
      tlb_test_command_reg[CTL_US_T] <= hit_entry.tag.user;
      tlb_test_command_reg[CTL_US_C] <= ~hit_entry.tag.user;
      tlb_test_command_reg[CTL_RW_T] <= hit_entry.tag.wr;
      tlb_test_command_reg[CTL_RW_C] <= ~hit_entry.tag.wr;
    end
  end

  // Test-data register: bus writes and lookup results.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tlb_test_result_reg <= DATA_RST;
    end else if (wr_data) begin
      tlb_test_result_reg <= avs_req.writedata & wmask;
    end else if (do_lookup) begin
      tlb_test_result_reg[DAT_HIT] <= one_hit;
      if (one_hit) begin
        tlb_test_result_reg[31:PHYS_LO] <= hit_entry.phys;
        tlb_test_result_reg[DAT_UNCACHED] <= hit_entry.uncached;
        tlb_test_result_reg[DAT_WTHRU] <= hit_entry.wthru;
        tlb_test_result_reg[DAT_LRU_LO +: LRU_W] <= lru_cur;
        tlb_test_result_reg[DAT_WAY_LO +: WAY_IDX_W] <= hit_way;
      end
    end
  end

  // Buffer storage: cleared at reset, written by a test write.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int w = 0; w < NUM_WAYS; w++) begin
        for (int s = 0; s < SETS_PER_WAY; s++) begin
          mem[w][s] <= '0;
        end
      end
    end else if (do_write) begin
      mem[target_way][set_idx] <= new_entry;
    end
  end

  // Replacement history: touched by each write and each single hit.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int s = 0; s < SETS_PER_WAY; s++) begin
        lru[s] <= LRU_RST;
      end
    end else if (do_write) begin
      lru[set_idx] <= plru_touch(lru_cur, target_way);
    end else if (do_lookup & one_hit) begin
      lru[set_idx] <= plru_touch(lru_cur, hit_way);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // A control write is followed by exactly one operation cycle.
  sequence s_start;
    wr_ctrl;
  endsequence
  sequence s_run_once;
    (state == ST_EXEC) ##1 (state == ST_IDLE);
  endsequence
  property p_ctrl_starts_op;
    s_start |=> s_run_once;
  endproperty
  a_ctrl_starts_op: assert property (p_ctrl_starts_op)
    else $error("Control write did not run one operation cycle.");

  // The hit flag reflects whether exactly one way matched.
  property p_hit_flag;
    do_lookup |=> tlb_test_result_reg[DAT_HIT] == $past(one_hit);
  endproperty
  a_hit_flag: assert property (p_hit_flag)
    else $error("Hit flag does not match the lookup outcome.");

  // A miss or multiple hit leaves every other field alone.
  property p_miss_keeps;
    do_lookup && !one_hit |=> $stable(tlb_test_result_reg[31:5])
      && $stable(tlb_test_result_reg[3:0]) && $stable(tlb_test_command_reg);
  endproperty
  a_miss_keeps: assert property (p_miss_keeps)
    else $error("Fields changed after a lookup miss.");

  // A single hit reports its way and physical page.
  property p_hit_way;
    do_lookup && one_hit |=> tlb_test_result_reg[3:2] == $past(hit_way)
      && tlb_test_result_reg[31:12] == $past(hit_entry.phys);
  endproperty
  a_hit_way: assert property (p_hit_way)
    else $error("Hit way or page not reported.");

  // History reported is the value before the lookup touched it.
  property p_lru_report;
    do_lookup && one_hit |=> tlb_test_result_reg[9:7] == $past(lru_cur);
  endproperty
  a_lru_report: assert property (p_lru_report)
    else $error("Reported history is not the prior value.");

  // A write leaves the target entry valid exactly as the control bit said.
  property p_write_valid;
    do_write |=> mem[$past(target_way)][$past(set_idx)].tag.valid
      == $past(tlb_test_command_reg[CTL_VALID]);
  endproperty
  a_write_valid: assert property (p_write_valid)
    else $error("Written entry valid bit is wrong.");

  // A forced write goes to the named way.
  property p_forced_way;
    do_write && tlb_test_result_reg[DAT_HIT] |=>
      mem[$past(tlb_test_result_reg[3:2])][$past(set_idx)].phys
        == $past(tlb_test_result_reg[31:12]);
  endproperty
  a_forced_way: assert property (p_forced_way)
    else $error("Forced write went to the wrong way.");

  // Reserved upper byte stays zero on the reduced variant.
  property p_reserved;
    REDUCED_ADDR |-> tlb_test_command_reg[31:24] == 8'h00
      && tlb_test_result_reg[31:24] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bits became nonzero.");

  // A write stores the physical page in the target entry.
  property p_write_stored;
    do_write |=> mem[$past(target_way)][$past(set_idx)].phys == $past(tlb_test_result_reg[31:12]);
  endproperty
  a_write_stored: assert property (p_write_stored)
    else $error("Physical page not stored on write.");
endmodule
`default_nettype wire

// ==== tlb_way_match.sv ====
`timescale 1ns/1ps
`default_nettype none
// Compares one stored tag with the lookup key and its attribute pairs.
module tlb_way_match (
  input wire tlb_test_pkg::tlb_tag_t stored,
  input wire logic [19:0] lin,
  input wire logic [5:0] pairs,
  output logic hit
);
  import tlb_test_pkg::*;

  // Each pair (true, complement) matches a stored 1 via true and a 0 via complement.
  logic d_ok;
  logic u_ok;
  logic w_ok;

  always_comb begin
    d_ok = (pairs[5] & stored.dirty) | (pairs[4] & ~stored.dirty);
    u_ok = (pairs[3] & stored.user) | (pairs[2] & ~stored.user);
    w_ok = (pairs[1] & stored.wr) | (pairs[0] & ~stored.wr);
    hit = stored.valid & (stored.lin == lin) & d_ok & u_ok & w_ok;
  end
endmodule
`default_nettype wire
